// >>> core/jtag_test_data_registers.sv
// Bypass, boundary scan and identification registers of the test port
//
// Notes on behaviour
// R01: The bypass register is a single shift stage between serial input and output.
// R02: Instructions BYPASS, CLAMP and HIGHZ route the serial path through the bypass stage.
// R03: The boundary register has a serial shift path and a separately latched parallel stage.
// R04: An identification register is provided for IDCODE and for the test-logic-reset state.
// R05: The identification register has 32 shift stages and a 32-bit parallel latch.
// R06: The identification register is selected under IDCODE and during test-logic-reset.
// R07: The identification word is revision, 15-bit part code, 11-bit maker code, and a one in bit 0.
// R08: Instructions are three bits: 111 bypass, 001 ident, 000/010 boundary, 011 clamp, 100 high-z.
// R09: With ident selected, the word is loaded on the rising edge that follows entry into capture.
// R10: In shift, the selected register moves one stage toward the output per rising edge.
// R11: On the falling edge in update, the selected shift stages are copied to the parallel latch.
// R12: The bypass stage captures a zero in the capture state.
`timescale 1ns/1ps
`default_nettype none
`include "jtag_dr_map.svh"
module jtag_test_data_registers #(
  parameter int                      BSR_WIDTH = `BSR_WIDTH_DEF,
  parameter logic [`ID_REV_WIDTH-1:0]   ID_REVISION = 5'h0_001,  // Arbitrary value
  parameter logic [`ID_PART_WIDTH-1:0]  ID_PART     = 15'h0_5a5, // Arbitrary value
  parameter logic [`ID_MAKER_WIDTH-1:0] ID_MAKER    = 11'h0_0aa  // Arbitrary value
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   test_clock_pin,
  input  wire logic                   test_serial_in,
  input  wire logic                   capture_phase,
  input  wire logic                   shift_phase,
  input  wire logic                   update_phase,
  input  wire logic                   reset_phase,
  input  wire jtag_dr_pkg::instr_t    instruction,
  input  wire logic [BSR_WIDTH-1:0]   bsr_pin_in,
  output logic                        test_serial_out,
  output logic                        test_serial_oe,
  output logic [`ID_WIDTH-1:0]        id_parallel,
  output logic [BSR_WIDTH-1:0]        bsr_drive,
  output logic                        pin_override,
  output logic                        pin_hiz
);
  import jtag_dr_pkg::*;

  // Reset brought into the test clock domain
  logic                 rst_s1_r;
  logic                 rst_s2_r;
  logic                 link_clear;
  // Boundary pin samples brought into the test clock domain
  logic [BSR_WIDTH-1:0] pin_s1_r;
  logic [BSR_WIDTH-1:0] pin_s2_r;
  // Register selection
  dr_sel_t              dr_sel;
  logic                 sel_bypass;
  logic                 sel_bsr;
  logic                 sel_id;
  logic                 mode_override;
  logic                 mode_hiz;
  logic                 ovr_tck_r;
  logic                 hiz_tck_r;
  // Register contents
  logic [`ID_WIDTH-1:0] id_value;
  logic [`ID_WIDTH-1:0] id_shift;
  logic [`ID_WIDTH-1:0] id_latch;
  logic [BSR_WIDTH-1:0] bsr_shift;
  logic [BSR_WIDTH-1:0] bsr_latch;
  logic                 bypass_r;
  logic                 bypass_nxt;
  logic                 serial_src;
  logic                 upd_tgl_r;
  // Reference clock side of the crossing
  logic                 tgl_s1_r;
  logic                 tgl_s2_r;
  logic                 tgl_s3_r;
  logic                 ovr_s1_r;
  logic                 ovr_s2_r;
  logic                 hiz_s1_r;
  logic                 hiz_s2_r;
  logic                 word_ready;

  // Whole ident word: revision, part, maker, fixed one at bit 0
  assign id_value = {ID_REVISION, ID_PART, ID_MAKER, `ID_FIXED_LSB}; // [R07]

  // Reset synchroniser; clear follows rst alone through two test clock stages, so the link clock must run
  always_ff @(posedge test_clock_pin) begin
    rst_s1_r <= rst;
    rst_s2_r <= rst_s1_r;
  end
  assign link_clear = rst_s2_r;

  // Pin samples pass two stages; bits may skew by one test clock while pins move
  always_ff @(posedge test_clock_pin) begin
    pin_s1_r <= bsr_pin_in;
    pin_s2_r <= pin_s1_r;
  end

  // Instruction decode; reset state forces ident, unknown codes fall to bypass
  function automatic dr_sel_t decode_sel(input instr_t ir, input logic tlr);
    if (tlr) begin
      decode_sel = SEL_ID;                               // [R06]
    end else begin
      case (ir)
        `IR_IDCODE: decode_sel = SEL_ID;                 // [R04] [R08]
        `IR_EXTEST,
        `IR_SAMPLE: decode_sel = SEL_BSR;                // [R08]
        `IR_BYPASS,
        `IR_CLAMP,
        `IR_HIGHZ:  decode_sel = SEL_BYPASS;             // [R02] [R08]
        default:    decode_sel = SEL_BYPASS;
      endcase
    end
  endfunction : decode_sel

  assign dr_sel        = decode_sel(instruction, reset_phase);
  assign sel_bypass    = (dr_sel == SEL_BYPASS);
  assign sel_bsr       = (dr_sel == SEL_BSR);
  assign sel_id        = (dr_sel == SEL_ID);
  assign mode_override = !reset_phase && (instruction == `IR_EXTEST || instruction == `IR_CLAMP);
  assign mode_hiz      = !reset_phase && (instruction == `IR_HIGHZ);

  // Mode levels registered on the test clock so the crossing never sees a decode glitch
  always_ff @(posedge test_clock_pin) begin
    if (link_clear) begin
      ovr_tck_r <= 1'h0;
      hiz_tck_r <= 1'h0;
    end else begin
      ovr_tck_r <= mode_override;                        // [R08]
      hiz_tck_r <= mode_hiz;                             // [R08]
    end
  end

  // Identification register, preloaded while the controller sits in reset
  scan_stage_chain #(
    .WIDTH (`ID_WIDTH)
  ) u_id_chain (
    .tck       (test_clock_pin),
    .clear     (link_clear),
    .load_en   (capture_phase && sel_id),                // [R09]
    .shift_en  (shift_phase && sel_id),                  // [R10]
    .update_en (update_phase && sel_id),                 // [R11]
    .preset_en (reset_phase),                            // [R05] [R06]
    .serial_in (test_serial_in),
    .load_val  (id_value),
    .shift_q   (id_shift),
    .latch_q   (id_latch)
  );

  // Boundary register: capture samples the pins, latch drives them
  scan_stage_chain #(
    .WIDTH (BSR_WIDTH)
  ) u_bsr_chain (
    .tck       (test_clock_pin),
    .clear     (link_clear),
    .load_en   (capture_phase && sel_bsr),               // [R03]
    .shift_en  (shift_phase && sel_bsr),                 // [R10]
    .update_en (update_phase && sel_bsr),                // [R03] [R11]
    .preset_en (1'h0),
    .serial_in (test_serial_in),
    .load_val  (pin_s2_r),
    .shift_q   (bsr_shift),
    .latch_q   (bsr_latch)
  );

  // Single bypass stage; capture loads zero so it differs from the ident one
  assign bypass_nxt = (capture_phase && sel_bypass) ? `BYPASS_CAPTURE :  // [R12]
                      (shift_phase && sel_bypass) ? test_serial_in : bypass_r; // [R01]
  always_ff @(posedge test_clock_pin) begin
    if (link_clear) begin
      bypass_r <= 1'h0;
    end else begin
      bypass_r <= bypass_nxt;
    end
  end

  // Output end of whichever register is selected
  assign serial_src = sel_bypass ? bypass_r :
                      sel_bsr    ? bsr_shift[0] : id_shift[0];

  // Serial output changes on the falling edge, giving the tester a half period of setup
  always_ff @(negedge test_clock_pin) begin
    if (link_clear) begin
      test_serial_out <= 1'h0;
      test_serial_oe  <= 1'h0;
    end else begin
      test_serial_out <= serial_src;                     // [R10]
      test_serial_oe  <= shift_phase;
    end
  end

  // Parallel ident word straight from its latch stage
  assign id_parallel = id_latch;

  // Toggle marks each boundary update; the latch then holds until the next one
  always_ff @(negedge test_clock_pin) begin
    if (link_clear) begin
      upd_tgl_r <= 1'h0;
    end else if (update_phase && sel_bsr) begin
      upd_tgl_r <= !upd_tgl_r;
    end
  end

  // Toggle and mode levels brought into the reference domain
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tgl_s1_r <= 1'h0;
      tgl_s2_r <= 1'h0;
      tgl_s3_r <= 1'h0;
      ovr_s1_r <= 1'h0;
      ovr_s2_r <= 1'h0;
      hiz_s1_r <= 1'h0;
      hiz_s2_r <= 1'h0;
    end else begin
      tgl_s1_r <= upd_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
      ovr_s1_r <= ovr_tck_r;
      ovr_s2_r <= ovr_s1_r;
      hiz_s1_r <= hiz_tck_r;
      hiz_s2_r <= hiz_s1_r;
    end
  end
  assign word_ready = tgl_s2_r ^ tgl_s3_r;

  // Latched word is stable here; updates closer than three reference cycles would be missed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bsr_drive    <= '0;
      pin_override <= 1'h0;
      pin_hiz      <= 1'h0;
    end else begin
      if (word_ready) begin
        bsr_drive <= bsr_latch;                          // [R03]
      end
      pin_override <= ovr_s2_r;
      pin_hiz      <= hiz_s2_r;
    end
  end

  // Checks on the test clock side
  bypass_one_stage_a: assert property ( // [R01]
    @(posedge test_clock_pin) disable iff (link_clear)
    (shift_phase && sel_bypass) |=> (bypass_r == $past(test_serial_in)))
    else $error("bypass stage did not take the serial input");

  bypass_route_a: assert property ( // [R02]
    @(posedge test_clock_pin) disable iff (link_clear)
    (!reset_phase && (instruction == `IR_BYPASS || instruction == `IR_CLAMP ||
      instruction == `IR_HIGHZ)) |-> sel_bypass)
    else $error("bypass path not selected");

  bsr_latch_hold_a: assert property ( // [R03]
    @(posedge test_clock_pin) disable iff (link_clear)
    (shift_phase && $past(shift_phase)) |-> $stable(bsr_latch))
    else $error("boundary latch moved while shifting");

  id_select_a: assert property ( // [R04]
    @(posedge test_clock_pin) disable iff (link_clear)
    (reset_phase || instruction == `IR_IDCODE) |-> sel_id)
    else $error("ident register not selected");

  id_preset_a: assert property ( // [R05]
    @(posedge test_clock_pin) disable iff (link_clear)
    reset_phase |=> (id_shift == id_value))
    else $error("ident shift stages not preset in reset state");

  id_first_bit_a: assert property ( // [R07]
    @(posedge test_clock_pin) disable iff (link_clear)
    (capture_phase && sel_id) |=> (test_serial_out == `ID_FIXED_LSB))
    else $error("ident word does not start with a one");

  id_capture_a: assert property ( // [R09]
    @(posedge test_clock_pin) disable iff (link_clear)
    (capture_phase && sel_id && !reset_phase) |=> (id_shift == id_value))
    else $error("ident word not captured");

  shift_advance_a: assert property ( // [R10]
    @(posedge test_clock_pin) disable iff (link_clear)
    (shift_phase && sel_id && !reset_phase) |=>
      (id_shift == {$past(test_serial_in), $past(id_shift[`ID_WIDTH-1:1])}))
    else $error("ident register did not advance one stage");

  update_latch_a: assert property ( // [R11]
    @(negedge test_clock_pin) disable iff (link_clear)
    (update_phase && sel_bsr) |=> (bsr_latch == $past(bsr_shift)))
    else $error("boundary latch missed update");

  bypass_zero_a: assert property ( // [R12]
    @(posedge test_clock_pin) disable iff (link_clear)
    (capture_phase && sel_bypass) |=> (bypass_r == `BYPASS_CAPTURE))
    else $error("bypass stage did not capture zero");

  bsr_capture_a: assert property ( // [R03]
    @(posedge test_clock_pin) disable iff (link_clear)
    (capture_phase && sel_bsr) |=> (bsr_shift == $past(pin_s2_r)))
    else $error("boundary register did not capture the pins");

  id_update_a: assert property ( // [R11]
    @(negedge test_clock_pin) disable iff (link_clear)
    (update_phase && sel_id && !reset_phase) |=> (id_latch == $past(id_shift)))
    else $error("ident latch missed update");

  serial_enable_a: assert property ( // [R10]
    @(negedge test_clock_pin) disable iff (link_clear)
    shift_phase |=> test_serial_oe)
    else $error("serial output not enabled while shifting");
endmodule : jtag_test_data_registers
`default_nettype wire

// >>> core/jtag_dr_map.svh
// Constants for the boundary-scan test data registers
`ifndef JTAG_DR_MAP_SVH
`define JTAG_DR_MAP_SVH

// Instruction codes, three bits wide
`define IR_WIDTH        3
`define IR_EXTEST       3'h0
`define IR_IDCODE       3'h1
`define IR_SAMPLE       3'h2
`define IR_CLAMP        3'h3
`define IR_HIGHZ        3'h4
`define IR_BYPASS       3'h7

// Identification word layout
`define ID_WIDTH        32
`define ID_PART_WIDTH   15
`define ID_MAKER_WIDTH  11
`define ID_REV_WIDTH    5
`define ID_FIXED_LSB    1'h1

// Bypass stage capture value
`define BYPASS_CAPTURE  1'h0

// Default boundary register length
`define BSR_WIDTH_DEF   16

`endif

// >>> core/jtag_dr_pkg.sv
// Types shared by the test data register design
`default_nettype none
package jtag_dr_pkg;
  typedef logic [2:0] instr_t;

  typedef enum logic [1:0] {
    SEL_BYPASS,
    SEL_BSR,
    SEL_ID
  } dr_sel_t;
endpackage : jtag_dr_pkg
`default_nettype wire

// >>> core/scan_stage_chain.sv
// Shift path plus falling-edge parallel latch for one test data register
`timescale 1ns/1ps
`default_nettype none
module scan_stage_chain #(
  parameter int WIDTH = 32
) (
  input  wire logic             tck,
  input  wire logic             clear,
  input  wire logic             load_en,
  input  wire logic             shift_en,
  input  wire logic             update_en,
  input  wire logic             preset_en,
  input  wire logic             serial_in,
  input  wire logic [WIDTH-1:0] load_val,
  output logic      [WIDTH-1:0] shift_q,
  output logic      [WIDTH-1:0] latch_q
);
  logic [WIDTH-1:0] shift_nxt;

  // Load wins over shift; data moves toward bit 0, the serial output end
  assign shift_nxt = (load_en || preset_en) ? load_val :
                     shift_en ? {serial_in, shift_q[WIDTH-1:1]} : shift_q;

  // Shift stages advance on the rising test clock edge
  always_ff @(posedge tck) begin
    if (clear) begin
      shift_q <= '0;
    end else begin
      shift_q <= shift_nxt;
    end
  end

  // Latch only on the falling edge so shifting never ripples to outputs
  always_ff @(negedge tck) begin
    if (clear) begin
      latch_q <= '0;
    end else if (preset_en) begin
      latch_q <= load_val;
    end else if (update_en) begin
      latch_q <= shift_q;
    end
  end
endmodule : scan_stage_chain
`default_nettype wire

// >>> verification/jtag_tester_model.sv
// Boundary-scan tester model driving the test side of the data registers
`timescale 1ns/1ps
`default_nettype none
module jtag_tester_model (
  output var logic                test_clock_pin,
  output var logic                test_serial_in,
  output var logic                capture_phase,
  output var logic                shift_phase,
  output var logic                update_phase,
  output var logic                reset_phase,
  output var jtag_dr_pkg::instr_t instruction,
  input  wire logic               test_serial_out
);
  import jtag_dr_pkg::*;

  // Idle levels; the test clock stands low outside frames
  initial begin
    test_clock_pin = 1'h0;
    test_serial_in = 1'h0;
    capture_phase  = 1'h0;
    shift_phase    = 1'h0;
    update_phase   = 1'h0;
    reset_phase    = 1'h0;
    instruction    = 3'h7;
  end

  // Whole test clocks; signals move 1 ns after each falling edge, clear of both edges
  task automatic tick(input int n);
    repeat (n) begin
      #15 test_clock_pin = 1'h1;
      #16 test_clock_pin = 1'h0;
      #1;
    end
  endtask : tick

  // Capture, n shifts, update; output bit sampled before each shifting edge
  task automatic scan(input instr_t ins, input int n, input logic [63:0] din, output logic [63:0] dout);
    dout = '0;
    instruction = ins;
    tick(1);
    capture_phase = 1'h1;
    tick(1);
    capture_phase = 1'h0;
    for (int i = 0; i < n; i++) begin
      shift_phase = 1'h1;
      dout[i] = test_serial_out;
      test_serial_in = din[i];
      tick(1);
    end
    shift_phase = 1'h0;
    // Released line shows the inverse so a stale bit cannot pass for data
    test_serial_in = ~test_serial_in;
    update_phase = 1'h1;
    tick(1);
    update_phase = 1'h0;
  endtask : scan

  // One clock in test-logic-reset
  task automatic run_reset();
    reset_phase = 1'h1;
    tick(1);
    reset_phase = 1'h0;
  endtask : run_reset
endmodule : jtag_tester_model
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the boundary-scan test data registers
`timescale 1ns/1ps
`default_nettype none
`include "jtag_dr_map.svh"
module tb;
  import jtag_dr_pkg::*;
  localparam logic [4:0]  REV     = 5'h0a;    // Arbitrary value
  localparam logic [14:0] PART    = 15'h1234; // Arbitrary value
  localparam logic [10:0] MAKER   = 11'h04d;  // Arbitrary value
  localparam logic [31:0] ID_WORD = {REV, PART, MAKER, `ID_FIXED_LSB};
  localparam logic [15:0] PINS    = 16'hc35a;
  typedef struct {instr_t ins; int n; logic [63:0] din; logic [63:0] exp; logic ovr; logic hiz;} row_t;
  logic        ref_clk, rst, tclk, s_in, cap, sh, upd, tlr, s_out, oe, ovr, hiz;
  instr_t      ins;
  logic [31:0] idp;
  logic [15:0] bsr;
  logic [15:0] pins;
  logic [63:0] dout;
  int          err_count, checked;
  row_t        rows [8];

  // Reference clock, 40 ns
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  jtag_tester_model tester (.test_clock_pin(tclk), .test_serial_in(s_in), .capture_phase(cap),
    .shift_phase(sh), .update_phase(upd), .reset_phase(tlr), .instruction(ins), .test_serial_out(s_out));

  jtag_test_data_registers #(.BSR_WIDTH(16), .ID_REVISION(REV), .ID_PART(PART), .ID_MAKER(MAKER)) dut (
    .ref_clk(ref_clk), .rst(rst), .test_clock_pin(tclk), .test_serial_in(s_in), .capture_phase(cap),
    .shift_phase(sh), .update_phase(upd), .reset_phase(tlr), .instruction(ins), .bsr_pin_in(pins),
    .test_serial_out(s_out), .test_serial_oe(oe), .id_parallel(idp), .bsr_drive(bsr),
    .pin_override(ovr), .pin_hiz(hiz));

  // Compare and count
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic results();
    $display("checks=%0d mismatches=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  // Watchdog, several times the expected run
  initial begin
    #100000;
    err_count++;
    results();
  end

  // Reset spans test clocks as well as reference clocks; every output must read zero after it
  task automatic apply_reset();
    @(posedge ref_clk);
    #1 rst = 1'h1;
    fork
      tester.tick(4);
      repeat (16) @(posedge ref_clk);
    join
    #1 rst = 1'h0;
    tester.tick(2);
    repeat (4) @(posedge ref_clk);
    #1;
    cmp(64'({s_out, oe, ovr, hiz}), 64'h0);
    cmp(64'(idp), 64'h0);
    cmp(64'(bsr), 64'h0);
    $display("test reset done");
  endtask : apply_reset

  // Main sequence
  initial begin
    rst = 1'h1;
    pins = PINS;
    err_count = 0;
    checked = 0;
    rows[0] = '{`IR_BYPASS, 8, 64'h5a, 64'hb4, 1'h0, 1'h0};
    rows[1] = '{`IR_CLAMP, 8, 64'h81, 64'h02, 1'h1, 1'h0};
    rows[2] = '{`IR_HIGHZ, 8, 64'h3c, 64'h78, 1'h0, 1'h1};
    rows[3] = '{3'h5, 4, 64'h0f, 64'h0e, 1'h0, 1'h0};
    rows[4] = '{3'h6, 4, 64'h09, 64'h02, 1'h0, 1'h0};
    rows[5] = '{`IR_IDCODE, 40, 64'h12_3456_78c3, 64'({8'hc3, ID_WORD}), 1'h0, 1'h0};
    rows[6] = '{`IR_EXTEST, 24, 64'h12_3456, 64'({8'h56, PINS}), 1'h1, 1'h0};
    rows[7] = '{`IR_SAMPLE, 24, 64'hab_cde1, 64'({8'he1, PINS}), 1'h0, 1'h0};
    apply_reset();
    // Table of ordinary scans; outputs read just after the reference edge, not on it
    for (int i = 0; i < 8; i++) begin
      tester.scan(rows[i].ins, rows[i].n, rows[i].din, dout);
      repeat (6) @(posedge ref_clk);
      #1;
      cmp(dout, rows[i].exp);
      cmp(64'({ovr, hiz}), 64'({rows[i].ovr, rows[i].hiz}));
      if (rows[i].ins == `IR_EXTEST || rows[i].ins == `IR_SAMPLE) cmp(64'(bsr), 64'(rows[i].din[23:8]));
      if (rows[i].ins == `IR_IDCODE) cmp(64'(idp), 64'(rows[i].din[39:8]));
      $display("test row %0d done", i);
    end
    // Bypass with a single shift shows only the captured zero
    tester.scan(`IR_BYPASS, 1, 64'h1, dout);
    cmp(dout, 64'h0);
    $display("test single bypass done");
    // Moved pins reach the next boundary capture after two test clocks of sync
    pins = 16'h0ff0;
    tester.tick(2);
    tester.scan(`IR_SAMPLE, 16, 64'h5a5a, dout);
    cmp(dout, 64'h0ff0);
    $display("test pin capture done");
    // Reset in mid-run clears both clock domains
    apply_reset();
    // Test-logic-reset forces the word into the cleared latch
    tester.run_reset();
    cmp(64'(idp), 64'(ID_WORD));
    // Zeros scanned in replace the word, then capture straight into update restores it
    tester.scan(`IR_IDCODE, 32, 64'h0, dout);
    cmp(dout, 64'(ID_WORD));
    cmp(64'(idp), 64'h0);
    tester.scan(`IR_IDCODE, 0, 64'h0, dout);
    cmp(64'(idp), 64'(ID_WORD));
    $display("test reset and capture-update done");
    results();
  end
endmodule : tb
`default_nettype wire
